// file: src/multi_channel_pwm_timer.sv
// twelve-counter, twelve-channel pulse-width timer with capture, dead-time and fading
//
// Summary of operation
// - twelve 32-bit auto-reload counters, own prescalers
// - count up, down or up-down, auto reload
// - 8-bit prescaler divides by 1 to 256
// - channels capture, count edges or compare
// - any channel may use any counter
// - channel independent or complement of any partner
// - edge-aligned and centre-aligned pulse placement
// - programmable dead-time with selectable mode
// - external sync, chaining and triggering of counters
// - repetition count delays working register updates
// - hardware duty ramp for LED fading
// - update event on overflow, underflow, init
// - events on start, capture, match, fade end
// - polarity, duty, period change at period boundary
// - quadrature encoder and Hall sensor decoding
`timescale 1ns/1ps
`include "pwm_params.svh"
module multi_channel_pwm_timer #(
  parameter int NCNT = `PWM_NCNT,
  parameter int NCH = `PWM_NCH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pwm_pkg::cnt_cfg_s [NCNT-1:0] cnt_cfg_i,
  input wire logic [NCNT-1:0] sw_init_i,
  input wire pwm_pkg::ch_cfg_s [NCH-1:0] ch_cfg_i,
  input wire logic [NCH-1:0] ch_in_i,
  output logic [NCH-1:0] ch_out_o,
  output logic [NCH-1:0] ch_oe_n_o,
  input wire logic ext_trig_i,
  input wire logic qa_i,
  input wire logic qb_i,
  input wire logic [2:0] hall_i,
  output logic [2:0] hall_state_o,
  output logic [NCNT-1:0][`PWM_CW-1:0] cnt_val_o,
  output logic [NCH-1:0][`PWM_CW-1:0] cap_val_o,
  output logic [NCNT-1:0] upd_evt_o,
  output logic [NCNT-1:0] start_evt_o,
  output logic [NCH-1:0] cap_evt_o,
  output logic [NCH-1:0] cmp_evt_o,
  output logic [NCH-1:0] fade_evt_o
);
  localparam int CW = `PWM_CW;

  // one step of a fade toward the target, never overshooting
  function automatic logic [CW-1:0] fade_next(input logic [CW-1:0] cur, input logic [CW-1:0] tgt,
                                              input logic [`PWM_FSW-1:0] step);
    logic [CW-1:0] s;
    s = {{(CW-`PWM_FSW){1'b0}}, step};
    if (cur < tgt) begin
      fade_next = (tgt - cur > s) ? cur + s : tgt;
    end else begin
      fade_next = (cur - tgt > s) ? cur - s : tgt;
    end
  endfunction

  // a selector names a real unit only below the unit count; larger codes name the external or Hall source, or nothing
  function automatic logic sel_in_range(input logic [`PWM_SELW-1:0] sel, input int n);
    sel_in_range = sel < `PWM_SELW'(n);
  endfunction

  logic [CW-1:0] cnt_r [NCNT];
  logic [NCNT-1:0] upd_w;
  logic [NCNT-1:0] upd_r;
  logic [NCNT-1:0] run_r;
  logic [NCH-1:0] wave_w;
  logic qa_r, qb_r, ext_r;
  logic [2:0] hall_r;

  // shared decoders: x4 quadrature, Hall change, external trigger edge
  wire qd_step = (qa_i ^ qa_r) ^ (qb_i ^ qb_r);
  wire qd_up = qa_i ^ qb_r;
  wire hall_chg = hall_i != hall_r;
  wire ext_rise = ext_trig_i & ~ext_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qa_r <= 1'b0;
      qb_r <= 1'b0;
      ext_r <= 1'b0;
      hall_r <= '0;
    end else begin
      qa_r <= qa_i;
      qb_r <= qb_i;
      ext_r <= ext_trig_i;
      hall_r <= hall_i;
    end
  end
  assign hall_state_o = hall_r;

  for (genvar k = 0; k < NCNT; k++) begin : g_cnt
    pwm_pkg::cnt_cfg_s c;
    logic [CW-1:0] per_act_r;
    logic [`PWM_PSW-1:0] psc_act_r, psc_r;
    logic [`PWM_REPW-1:0] rep_r;
    logic down_r;
    assign c = cnt_cfg_i[k];

    // chaining uses the registered update of another counter, so no loops form
    wire src_cnt = sel_in_range(c.src, NCNT);
    wire trig = src_cnt ? upd_r[c.src] : (c.src == `PWM_SRC_EXT) ? ext_rise :
                (c.src == `PWM_SRC_HALL) ? hall_chg : 1'b0;
    wire gate = src_cnt ? run_r[c.src] : (c.src == `PWM_SRC_EXT) ? ext_trig_i : 1'b1;
    wire run_nxt = c.en & (run_r[k] | (c.sync != pwm_pkg::SYNC_TRIG) | trig);
    wire gate_ok = (c.sync != pwm_pkg::SYNC_GATE) | gate;
    wire psc_hit = psc_r == psc_act_r;
    wire tick = run_r[k] & ((c.sync == pwm_pkg::SYNC_EXTCLK) ? trig :
                (c.mode == pwm_pkg::CNT_ENC) ? qd_step : (psc_hit & gate_ok));
    wire is_ud = c.mode == pwm_pkg::CNT_UPDOWN;
    wire up = (c.mode == pwm_pkg::CNT_UP) | (is_ud & ~down_r) |
              ((c.mode == pwm_pkg::CNT_ENC) & qd_up);
    wire at_top = cnt_r[k] == per_act_r;
    wire at_bot = cnt_r[k] == '0;
    wire wrap = tick & (up ? at_top : at_bot);
    wire reinit = sw_init_i[k] | ((c.sync == pwm_pkg::SYNC_RESET) & trig);
    assign upd_w[k] = reinit | (wrap & (rep_r == '0));

    // up-down turns round in place at either end, giving a symmetric period
    logic [CW-1:0] cnt_nxt;
    always_comb begin
      cnt_nxt = cnt_r[k];
      if (reinit) begin
        cnt_nxt = (c.mode == pwm_pkg::CNT_DOWN) ? c.period : '0;
      end else if (tick) begin
        if (up) begin
          cnt_nxt = at_top ? (is_ud ? cnt_r[k] : '0) : cnt_r[k] + 1'b1;
        end else begin
          cnt_nxt = at_bot ? (is_ud ? cnt_r[k] : per_act_r) : cnt_r[k] - 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_r[k] <= '0;
        per_act_r <= '0;
        psc_act_r <= '0;
        psc_r <= '0;
        rep_r <= '0;
        down_r <= 1'b0;
        run_r[k] <= 1'b0;
        upd_r[k] <= 1'b0;
        start_evt_o[k] <= 1'b0;
      end else begin
        cnt_r[k] <= cnt_nxt;
        run_r[k] <= run_nxt;
        upd_r[k] <= upd_w[k];
        start_evt_o[k] <= run_nxt & ~run_r[k];
        if (reinit || !run_r[k] || psc_hit) begin
          psc_r <= '0;
        end else if (gate_ok) begin
          psc_r <= psc_r + 1'b1;
        end
        if (upd_w[k]) begin
          per_act_r <= c.period;
          psc_act_r <= c.psc;
          rep_r <= c.rep;
        end else if (wrap) begin
          rep_r <= rep_r - 1'b1;
        end
        if (reinit || !is_ud) begin
          down_r <= 1'b0;
        end else if (wrap) begin
          down_r <= ~down_r;
        end
      end
    end
    assign cnt_val_o[k] = cnt_r[k];
    assign upd_evt_o[k] = upd_r[k];
  end

  for (genvar j = 0; j < NCH; j++) begin : g_ch
    pwm_pkg::ch_cfg_s c;
    logic [CW-1:0] cmp_act_r, cap_r;
    logic pol_act_r, dout_r, pin_r, in_r, match_r;
    logic [`PWM_DTW-1:0] dtc_r;
    assign c = ch_cfg_i[j];

    wire sel_ok = sel_in_range(c.sel, NCNT);
    wire [CW-1:0] cv = sel_ok ? cnt_r[c.sel] : '0;
    wire cu = sel_ok & upd_w[c.sel];
    wire is_cmp = c.mode == pwm_pkg::CH_CMP;
    // alignment follows the counter mode: up or down gives edge, up-down gives centre
    assign wave_w[j] = is_cmp & (cv < cmp_act_r);
    wire pair_ok = sel_in_range(c.pair_sel, NCH);
    wire target = c.pair_en ? (pair_ok & ~wave_w[c.pair_sel]) : wave_w[j];
    wire on_lvl = ~c.dt_mode;
    wire match = is_cmp & (cv == cmp_act_r);
    wire rise = ch_in_i[j] & ~in_r;
    wire fall = ~ch_in_i[j] & in_r;
    wire hit = ((c.edge_sel == pwm_pkg::EDGE_RISE) & rise) |
               ((c.edge_sel == pwm_pkg::EDGE_FALL) & fall) |
               ((c.edge_sel == pwm_pkg::EDGE_BOTH) & (rise | fall));
    wire [CW-1:0] cmp_nxt = c.fade_en ? fade_next(cmp_act_r, c.cmp, c.fade_step) : c.cmp;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cmp_act_r <= '0;
        pol_act_r <= 1'b0;
        dout_r <= 1'b0;
        pin_r <= 1'b0;
        dtc_r <= '0;
        in_r <= 1'b0;
        match_r <= 1'b0;
        cap_r <= '0;
        cap_evt_o[j] <= 1'b0;
        cmp_evt_o[j] <= 1'b0;
        fade_evt_o[j] <= 1'b0;
      end else begin
        in_r <= ch_in_i[j];
        match_r <= match;
        cmp_evt_o[j] <= match & ~match_r;
        fade_evt_o[j] <= cu & c.fade_en & (cmp_act_r != c.cmp) & (cmp_nxt == c.cmp);
        cap_evt_o[j] <= (c.mode == pwm_pkg::CH_CAPT) & hit;
        if (cu) begin
          cmp_act_r <= cmp_nxt;
          pol_act_r <= c.pol;
        end
        if ((c.mode == pwm_pkg::CH_CAPT) && hit) begin
          cap_r <= cv;
        end else if ((c.mode == pwm_pkg::CH_COUNT) && hit) begin
          cap_r <= cap_r + 1'b1;
        end
        // moves toward the on level wait dt cycles; moves to off are immediate
        if (dout_r == target) begin
          dtc_r <= '0;
        end else if ((target == on_lvl) && (dtc_r < c.dt)) begin
          dtc_r <= dtc_r + 1'b1;
        end else begin
          dout_r <= target;
          dtc_r <= '0;
        end
        pin_r <= dout_r ^ pol_act_r;
      end
    end
    assign ch_out_o[j] = pin_r;
    assign ch_oe_n_o[j] = ~is_cmp;
    assign cap_val_o[j] = cap_r;
  end
endmodule // multi_channel_pwm_timer

// file: src/pwm_params.svh
// constants for the multi-channel pulse-width timer
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH
`define PWM_NCNT 12
`define PWM_NCH 12
`define PWM_CW 32
`define PWM_PSW 8
`define PWM_REPW 8
`define PWM_SELW 4
`define PWM_DTW 8
`define PWM_FSW 16
`define PWM_SRC_EXT 4'hC
`define PWM_SRC_HALL 4'hD
`endif

// file: src/pwm_pkg.sv
// types for the multi-channel pulse-width timer
`include "pwm_params.svh"
package pwm_pkg;
  typedef enum logic [1:0] {CNT_UP = 2'h0, CNT_DOWN = 2'h1, CNT_UPDOWN = 2'h3, CNT_ENC = 2'h2} cnt_mode_e;
  typedef enum logic [2:0] {
    SYNC_NONE = 3'h0, SYNC_RESET = 3'h1, SYNC_GATE = 3'h3, SYNC_TRIG = 3'h2, SYNC_EXTCLK = 3'h6
  } sync_mode_e;
  typedef enum logic [1:0] {CH_CMP = 2'h0, CH_CAPT = 2'h1, CH_COUNT = 2'h3, CH_OFF = 2'h2} ch_mode_e;
  typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_BOTH = 2'h3, EDGE_NONE = 2'h2} edge_e;
  typedef struct packed {
    logic en;
    cnt_mode_e mode;
    sync_mode_e sync;
    logic [`PWM_SELW-1:0] src;
    logic [`PWM_PSW-1:0] psc;
    logic [`PWM_REPW-1:0] rep;
    logic [`PWM_CW-1:0] period;
  } cnt_cfg_s;
  typedef struct packed {
    ch_mode_e mode;
    logic [`PWM_SELW-1:0] sel;
    edge_e edge_sel;
    logic pol;
    logic pair_en;
    logic [`PWM_SELW-1:0] pair_sel;
    logic dt_mode;
    logic [`PWM_DTW-1:0] dt;
    logic fade_en;
    logic [`PWM_FSW-1:0] fade_step;
    logic [`PWM_CW-1:0] cmp;
  } ch_cfg_s;
endpackage

// file: sim/pwm_timer_checker.sv
// assertion checker for counter 0 and channel 0 of the pulse-width timer
`timescale 1ns/1ps
module pwm_timer_checker #(
  parameter int NCNT = 12,
  parameter int NCH = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pwm_pkg::cnt_cfg_s [NCNT-1:0] cnt_cfg_i,
  input wire logic [NCNT-1:0] sw_init_i,
  input wire pwm_pkg::ch_cfg_s [NCH-1:0] ch_cfg_i,
  input wire logic [NCH-1:0] ch_in_i,
  input wire logic [NCH-1:0] ch_oe_n_o,
  input wire logic [NCNT-1:0][31:0] cnt_val_o,
  input wire logic [NCH-1:0][31:0] cap_val_o,
  input wire logic [NCNT-1:0] upd_evt_o,
  input wire logic [NCNT-1:0] start_evt_o,
  input wire logic [NCH-1:0] cap_evt_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rise_seen;
    $rose(ch_in_i[0]) && ch_cfg_i[0].edge_sel == pwm_pkg::EDGE_RISE;
  endsequence
  // three idle cycles so a tick already in flight has landed
  sequence halted;
    (!cnt_cfg_i[0].en && !sw_init_i[0] && cnt_cfg_i[0].sync == pwm_pkg::SYNC_NONE) [*3];
  endsequence
  oe_enable_a: assert property (ch_oe_n_o[0] == (ch_cfg_i[0].mode != pwm_pkg::CH_CMP))
    else $error("pin enable does not follow channel mode");
  init_update_a: assert property (sw_init_i[0] |=> upd_evt_o[0])
    else $error("no update event after software init");
  init_zero_a: assert property (sw_init_i[0] && cnt_cfg_i[0].mode == pwm_pkg::CNT_UP
    |=> cnt_val_o[0] == 32'h00000000)
    else $error("up counter not cleared by init");
  init_down_a: assert property (sw_init_i[0] && cnt_cfg_i[0].en && cnt_cfg_i[0].mode ==
    pwm_pkg::CNT_DOWN |=> cnt_val_o[0] == $past(cnt_cfg_i[0].period))
    else $error("down counter not loaded with period");
  capture_event_a: assert property (rise_seen and ch_cfg_i[0].mode == pwm_pkg::CH_CAPT
    |=> cap_evt_o[0])
    else $error("capture event missing");
  capture_idle_a: assert property (ch_cfg_i[0].mode != pwm_pkg::CH_CAPT |=> !cap_evt_o[0])
    else $error("capture event outside capture mode");
  edge_count_a: assert property (rise_seen and ch_cfg_i[0].mode == pwm_pkg::CH_COUNT
    |=> cap_val_o[0] == $past(cap_val_o[0]) + 1)
    else $error("edge count did not advance");
  start_event_a: assert property ($rose(cnt_cfg_i[0].en) && cnt_cfg_i[0].sync ==
    pwm_pkg::SYNC_NONE |-> ##[1:3] start_evt_o[0])
    else $error("start event missing");
  halt_hold_a: assert property (halted |-> $stable(cnt_val_o[0]))
    else $error("disabled counter moved");
endmodule // pwm_timer_checker
bind multi_channel_pwm_timer pwm_timer_checker #(.NCNT(NCNT), .NCH(NCH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cnt_cfg_i(cnt_cfg_i), .sw_init_i(sw_init_i),
  .ch_cfg_i(ch_cfg_i), .ch_in_i(ch_in_i), .ch_oe_n_o(ch_oe_n_o), .cnt_val_o(cnt_val_o),
  .cap_val_o(cap_val_o), .upd_evt_o(upd_evt_o), .start_evt_o(start_evt_o),
  .cap_evt_o(cap_evt_o));

// file: sim/enc_model.sv
// quadrature encoder and hall sensor stand-in
`timescale 1ns/1ps
module enc_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic dir_i,
  output logic qa_o,
  output logic qb_o,
  output logic [2:0] hall_o
);
  logic [1:0] ph_r = 2'h0;
  always_ff @(posedge clk_i) begin
    if (step_i) begin
      ph_r <= dir_i ? ph_r + 2'h1 : ph_r - 2'h1;
    end
  end
  // gray order on qa and qb: one line moves per step, as a real disc does; hall_o moves two lines per step
  assign qa_o = ph_r[1] ^ ph_r[0];
  assign qb_o = ph_r[1];
  assign hall_o = {ph_r, qa_o};
endmodule // enc_model

// file: sim/multi_channel_pwm_timer_test.sv
// self-checking bench for the pulse-width timer
`timescale 1ns/1ps
module multi_channel_pwm_timer_test;
  logic clk = 0, rst = 1, step = 0, dir = 1, qa, qb;
  logic [11:0] init = '0, chin = '0, chout, oen, upd, sev, cev, mev, fev;
  logic [2:0] hall, hst;
  logic [11:0][31:0] cv, capv;
  pwm_pkg::cnt_cfg_s [11:0] cc = '0;
  pwm_pkg::ch_cfg_s [11:0] hc = '0;
  pwm_pkg::edge_e eds [3] = '{pwm_pkg::EDGE_RISE, pwm_pkg::EDGE_FALL, pwm_pkg::EDGE_BOTH};
  int mismatches = 0, checked = 0, cyc = 0;
  int k, j, j2, per, psc, rep, cmp, dt, pl, g, n, hi, hi2, ev;
  always #10 clk = ~clk;
  multi_channel_pwm_timer u_dut (.clk_i(clk), .rst_i(rst), .cnt_cfg_i(cc), .sw_init_i(init),
    .ch_cfg_i(hc), .ch_in_i(chin), .ch_out_o(chout), .ch_oe_n_o(oen), .ext_trig_i(1'b0),
    .qa_i(qa), .qb_i(qb), .hall_i(hall), .hall_state_o(hst), .cnt_val_o(cv), .cap_val_o(capv),
    .upd_evt_o(upd), .start_evt_o(sev), .cap_evt_o(cev), .cmp_evt_o(mev), .fade_evt_o(fev));
  enc_model u_enc (.clk_i(clk), .step_i(step), .dir_i(dir), .qa_o(qa), .qb_o(qb), .hall_o(hall));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask
  // cycles up to the next update pulse of counter k
  task automatic gap(output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (upd[k] !== 1'b1 && c < 400);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(32'hc4a0930b));
    tick(5);
    rst = 0;
    chk(upd, 32'h0, "upd_evt");
    for (int i = 0; i < 6; i++) begin
      k = i < 2 ? 0 : $urandom % 12;
      j = i < 2 ? 0 : $urandom % 12;
      j2 = (j + 1) % 12;
      per = 2 + $urandom % 5;
      psc = $urandom % 4;
      rep = $urandom % 3;
      cmp = 1 + $urandom % (per - 1);
      dt = $urandom % 2;
      // centre mode: whole up-down cycles per window, no dead-time
      if (i % 3 == 2) begin
        rep = 1;
        dt = 0;
      end
      pl = $urandom % 2;
      cc[k] = '0;
      cc[k].en = 1'b1;
      cc[k].mode = (i % 3 == 0) ? pwm_pkg::CNT_UP :
                   (i % 3 == 1) ? pwm_pkg::CNT_DOWN : pwm_pkg::CNT_UPDOWN;
      cc[k].psc = 8'(psc);
      cc[k].rep = 8'(rep);
      cc[k].period = 32'(per);
      hc[j] = '0;
      hc[j].sel = 4'(k);
      hc[j].cmp = 32'(cmp);
      hc[j].dt = 8'(dt);
      hc[j2] = '0;
      hc[j2].sel = 4'(k);
      hc[j2].pair_en = 1'b1;
      hc[j2].pair_sel = 4'(j);
      hc[j2].pol = pl[0];
      init[k] = 1'b1;
      tick(1);
      init = '0;
      g = (per + 1) * (psc + 1) * (rep + 1);
      gap(n);
      gap(n);
      hi = 0;
      hi2 = 0;
      ev = 0;
      repeat (g) begin
        tick(1);
        hi += chout[j];
        hi2 += chout[j2];
        ev += mev[j];
      end
      chk(hi, (cmp * (psc + 1) - dt) * (rep + 1), "duty");
      chk(hi2, pl ? cmp * (psc + 1) * (rep + 1) : g - cmp * (psc + 1) * (rep + 1), "pair");
      chk(ev, rep + 1, "cmp_evt");
      gap(n);
      gap(n);
      chk(n, g, "update gap");
      chk(oen[j], 1'b0, "oe_n");
      cc[k].en = 1'b0;
      tick(4);
    end
    cc[0].en = 1'b1;
    cc[0].period = 32'h0000FFFF;
    for (int m = 0; m < 2; m++) begin
      for (int e = 0; e < 3; e++) begin
        hc[0] = '0;
        hc[0].mode = m ? pwm_pkg::CH_COUNT : pwm_pkg::CH_CAPT;
        hc[0].edge_sel = eds[e];
        tick(3);
        n = capv[0];
        ev = 0;
        for (int t = 0; t < 18; t++) begin
          chin[0] = (t % 3 == 0) ? ~chin[0] : chin[0];
          tick(1);
          ev += cev[0];
        end
        chk(m ? capv[0] - n : ev, e == 2 ? 6 : 3, "edges");
        chk(m ? ev : 0, 0, "count cap_evt");
      end
    end
    cc[2] = '0;
    cc[2].en = 1'b1;
    cc[2].period = 32'h00000003;
    hc[2] = '0;
    hc[2].sel = 4'h2;
    init[2] = 1'b1;
    tick(1);
    init = '0;
    tick(8);
    hc[2].fade_en = 1'b1;
    hc[2].fade_step = 16'h0001;
    hc[2].cmp = 32'h00000003;
    ev = 0;
    repeat (40) begin
      tick(1);
      ev += fev[2];
    end
    chk(ev, 1, "fade_evt");
    cc[1] = '0;
    cc[1].en = 1'b1;
    cc[1].mode = pwm_pkg::CNT_ENC;
    cc[1].period = 32'h000000FF;
    init[1] = 1'b1;
    tick(1);
    init = '0;
    n = 4 + $urandom % 8;
    hi = $urandom % 4;
    for (int s = 0; s < n + hi; s++) begin
      dir = s < n;
      step = 1'b1;
      tick(1);
      step = 1'b0;
      tick(2);
    end
    tick(3);
    chk(cv[1], n - hi, "encoder");
    chk(hst, hall, "hall");
    finish_test;
  end
endmodule // multi_channel_pwm_timer_test
